// >>> inc/bsd_map.svh
// offsets, fields, reset values and timing counts of the bus controller
`ifndef BSD_MAP_SVH
`define BSD_MAP_SVH

// ----------------------------------------------------------------
// avalon register offsets (byte addresses)
// ----------------------------------------------------------------
`define BSD_OFS_CTRL_A 5'h00
`define BSD_OFS_CTRL_B 5'h04
`define BSD_OFS_ADDR 5'h08
`define BSD_OFS_WDATA 5'h0c
`define BSD_OFS_CMD 5'h10
`define BSD_OFS_STATUS 5'h14
`define BSD_OFS_RDATA 5'h18
`define BSD_OFS_BANK 5'h1c

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define BSD_CTRL_A_EN_BIT 7
`define BSD_CTRL_A_ENABLE 8'h80
`define BSD_CTRL_B_REQUIRED 8'h00
`define BSD_CTRL_RST 8'h00
`define BSD_CMD_WRITE_BIT 0
`define BSD_CMD_READ_BIT 1
`define BSD_ST_BUSY_BIT 0
`define BSD_ST_DONE_BIT 1
`define BSD_ST_ERR_BIT 2
`define BSD_ST_REGION_LO 4
`define BSD_ST_BANK_LO 8
`define BSD_BANK_RST 4'h0
`define BSD_BANK_MASK 8'h0f

// ----------------------------------------------------------------
// board memory map
// ----------------------------------------------------------------
`define BSD_SRAM_LO 16'h2200
`define BSD_SRAM_HI 16'ha1ff
`define BSD_EXP_LO 16'ha200
`define BSD_EXP_HI 16'hfeff
`define BSD_REG_LO 16'hff00
`define BSD_REG_HI 16'hffff
`define BSD_BANK_SEL_ADDR 16'hff01
`define BSD_BANK_BYTES 32768
`define BSD_NUM_BANKS 16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BSD_CLK_NS 50
`define BSD_STROBE_NS 100
`define BSD_STROBE_CYC ((`BSD_STROBE_NS + `BSD_CLK_NS - 1) / `BSD_CLK_NS)

`endif

// >>> inc/bsd_pkg.sv
// types shared by the external bus controller
package bsd_pkg;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSD_RGN_INTERNAL = 2'b00,
    BSD_RGN_SRAM = 2'b01,
    BSD_RGN_EXP = 2'b10,
    BSD_RGN_BOARD = 2'b11
  } bsd_region_t;

  typedef enum logic [2:0] {
    BSD_ST_IDLE = 3'b000,
    BSD_ST_ADDR = 3'b001,
    BSD_ST_LATCH = 3'b010,
    BSD_ST_STROBE = 3'b011,
    BSD_ST_RECOVER = 3'b100
  } bsd_state_t;

  // ----------------------------------------------------------------
  // pin bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ad;
    logic ad_oe;
    logic [7:0] a_hi;
    logic wr_b;
    logic rd_b;
    logic ale;
  } bsd_pins_t;

  function automatic logic bsd_in_range(input logic [15:0] a,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    bsd_in_range = (a >= lo) && (a <= hi);
  endfunction

endpackage

// >>> logic/bsd_region_dec.sv
// classifies a host address into the board's windows
`timescale 1ns/1ps
`default_nettype none
`include "bsd_map.svh"
module bsd_region_dec
  import bsd_pkg::*;
(
  input wire logic [15:0] addr_i,
  output bsd_region_t region_o,
  output logic bank_sel_o
);

  // ----------------------------------------------------------------
  // window decode
  // ----------------------------------------------------------------
  wire in_sram = bsd_in_range(addr_i, `BSD_SRAM_LO, `BSD_SRAM_HI);
  wire in_exp = bsd_in_range(addr_i, `BSD_EXP_LO, `BSD_EXP_HI);
  wire in_reg = bsd_in_range(addr_i, `BSD_REG_LO, `BSD_REG_HI);

  // windows are disjoint, board registers never alias sram or port
  assign region_o = in_sram ? BSD_RGN_SRAM :
                    in_exp ? BSD_RGN_EXP :
                    in_reg ? BSD_RGN_BOARD : BSD_RGN_INTERNAL;
  assign bank_sel_o = (addr_i == `BSD_BANK_SEL_ADDR);

endmodule
`default_nettype wire

// >>> logic/bsd_pin_drv.sv
// registers the external bus pins so every pin leaves a flip-flop
`timescale 1ns/1ps
`default_nettype none
module bsd_pin_drv
  import bsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire bsd_pins_t pins_nxt_i,
  output bsd_pins_t pins_o
);

  // ----------------------------------------------------------------
  // pin register
  // ----------------------------------------------------------------
  bsd_pins_t pins_r;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pins_r <= '{ad: 8'h00, ad_oe: 1'b0, a_hi: 8'h00,
                  wr_b: 1'b1, rd_b: 1'b1, ale: 1'b0};
    else
      pins_r <= pins_nxt_i;
  end

  assign pins_o = pins_r;

endmodule
`default_nettype wire

// >>> logic/bsd_host_ctrl.sv
// host controller: avalon registers in, multiplexed memory bus out
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bsd_map.svh"
module bsd_host_ctrl
  import bsd_pkg::*;
#(
  parameter int STROBE_CYC = `BSD_STROBE_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [7:0] host_port_low_addr_data_i,
  output logic [7:0] host_port_low_addr_data_o,
  output logic host_port_low_addr_data_oe_o,
  output logic [7:0] host_port_high_addr_o,
  output logic wr_b_o,
  output logic rd_b_o,
  output logic ale_o
);

  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] host_ext_mem_control_a_r;
  logic [7:0] host_ext_mem_control_b_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [3:0] bank_r;
  logic [3:0] bank_nxt;
  logic done_r;
  logic done_nxt;
  logic err_r;
  logic err_nxt;
  logic op_read_r;
  logic op_read_nxt;
  bsd_region_t region_r;
  bsd_region_t region_nxt;
  bsd_state_t state_r;
  bsd_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [31:0] readdata_r;
  logic [31:0] readdata_nxt;
  logic waitrequest_r;
  logic waitrequest_nxt;
  bsd_pins_t pins_nxt;
  bsd_pins_t pins;

  // ----------------------------------------------------------------
  // avalon decode
  // ----------------------------------------------------------------
  wire [4:0] ofs = {avs_address_i[4:2], 2'b00};
  wire sel_ctrl_a = (ofs == `BSD_OFS_CTRL_A);
  wire sel_ctrl_b = (ofs == `BSD_OFS_CTRL_B);
  wire sel_addr = (ofs == `BSD_OFS_ADDR);
  wire sel_wdata = (ofs == `BSD_OFS_WDATA);
  wire sel_cmd = (ofs == `BSD_OFS_CMD);
  wire sel_status = (ofs == `BSD_OFS_STATUS);
  wire sel_rdata = (ofs == `BSD_OFS_RDATA);
  wire sel_bank = (ofs == `BSD_OFS_BANK);
  wire req = avs_read_i | avs_write_i;
  wire busy = (state_r != BSD_ST_IDLE);
  // a command write waits out a running bus cycle: back-pressure
  wire stall = sel_cmd & avs_write_i & busy;
  wire commit = req & ~waitrequest_r;
  wire wr_commit = avs_write_i & ~waitrequest_r;

  // ----------------------------------------------------------------
  // command qualification
  // ----------------------------------------------------------------
  bsd_region_t cmd_region;
  logic cmd_bank_sel;

  bsd_region_dec u_region_dec
  (
    .addr_i(addr_r),
    .region_o(cmd_region),
    .bank_sel_o(cmd_bank_sel)
  );

  wire if_enabled = host_ext_mem_control_a_r[`BSD_CTRL_A_EN_BIT];
  wire ctrl_b_ok = (host_ext_mem_control_b_r == `BSD_CTRL_B_REQUIRED);
  wire cmd_wr = avs_writedata_i[`BSD_CMD_WRITE_BIT];
  wire cmd_rd = avs_writedata_i[`BSD_CMD_READ_BIT];
  wire cmd_hit = wr_commit & sel_cmd & (cmd_wr | cmd_rd);
  // internal addresses get no bus cycle, so they are refused; their upper byte still shows on the high address pins
  wire cmd_bad = ~if_enabled | ~ctrl_b_ok | (cmd_wr & cmd_rd) |
                 (cmd_region == BSD_RGN_INTERNAL);
  wire start = cmd_hit & ~cmd_bad;
  wire refuse = cmd_hit & cmd_bad;
  wire strobe_end = (state_r == BSD_ST_STROBE) && (cnt_r == 4'h0);
  wire cycle_end = (state_r == BSD_ST_RECOVER);
  wire done_clr = wr_commit & sel_status &
                  avs_writedata_i[`BSD_ST_DONE_BIT];
  wire err_clr = wr_commit & sel_status & avs_writedata_i[`BSD_ST_ERR_BIT];
  // board tracks the bank once its register write finished
  wire bank_upd = cycle_end & ~op_read_r & (region_r == BSD_RGN_BOARD) &
                  cmd_bank_sel;

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    op_read_nxt = op_read_r;
    region_nxt = region_r;
    case (state_r)
      BSD_ST_IDLE:
      begin
        if (start)
        begin
          state_nxt = BSD_ST_ADDR;
          op_read_nxt = cmd_rd;
          region_nxt = cmd_region;
        end
      end
      BSD_ST_ADDR:
        state_nxt = BSD_ST_LATCH;
      BSD_ST_LATCH:
      begin
        state_nxt = BSD_ST_STROBE;
        cnt_nxt = STROBE_LAST;
      end
      BSD_ST_STROBE:
      begin
        if (cnt_r == 4'h0)
          state_nxt = BSD_ST_RECOVER;
        else
          cnt_nxt = cnt_r - 4'h1;
      end
      BSD_ST_RECOVER:
        state_nxt = BSD_ST_IDLE;
      default:
        state_nxt = BSD_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // pin values for the next cycle
  // ----------------------------------------------------------------
  // writes to the bank register carry zeros in the upper nibble
  wire [7:0] out_data = cmd_bank_sel ?
                        (wdata_r & `BSD_BANK_MASK) : wdata_r;

  always_comb
  begin
    pins_nxt = '{ad: 8'h00, ad_oe: 1'b0, a_hi: 8'h00,
                 wr_b: 1'b1, rd_b: 1'b1, ale: 1'b0};
    if (if_enabled)
    begin
      pins_nxt.a_hi = addr_r[15:8];
      case (state_nxt)
        BSD_ST_ADDR:
        begin
          pins_nxt.ad = addr_r[7:0];
          pins_nxt.ad_oe = 1'b1;
          pins_nxt.ale = 1'b1;
        end
        BSD_ST_LATCH:
        begin
          // address held past the falling latch strobe
          pins_nxt.ad = addr_r[7:0];
          pins_nxt.ad_oe = 1'b1;
        end
        BSD_ST_STROBE:
        begin
          pins_nxt.ad = out_data;
          pins_nxt.ad_oe = ~op_read_nxt;
          pins_nxt.wr_b = op_read_nxt;
          pins_nxt.rd_b = ~op_read_nxt;
        end
        BSD_ST_RECOVER:
        begin
          // write data kept one cycle past the strobe for hold time
          pins_nxt.ad = out_data;
          pins_nxt.ad_oe = ~op_read_r;
        end
        default:
          pins_nxt.ad_oe = 1'b0;
      endcase
    end
  end

  bsd_pin_drv u_pin_drv
  (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pins_nxt_i(pins_nxt),
    .pins_o(pins)
  );

  // ----------------------------------------------------------------
  // flags, bank shadow and read data
  // ----------------------------------------------------------------
  // one byte per read, taken on the last strobe edge
  assign rdata_nxt = (strobe_end & op_read_r) ?
                     host_port_low_addr_data_i : rdata_r;
  assign bank_nxt = bank_upd ? out_data[3:0] : bank_r;
  // set beats clear when both land on one edge
  assign done_nxt = cycle_end | (done_r & ~done_clr);
  assign err_nxt = refuse | (err_r & ~err_clr);

  // ----------------------------------------------------------------
  // avalon answer
  // ----------------------------------------------------------------
  wire [31:0] status_word = {20'h00000, bank_r, 2'b00, region_r, 1'b0,
                             err_r, done_r, busy};

  always_comb
  begin
    readdata_nxt = readdata_r;
    if (avs_read_i & waitrequest_r)
    begin
      readdata_nxt = 32'h00000000;
      if (sel_ctrl_a)
        readdata_nxt = {24'h000000, host_ext_mem_control_a_r};
      if (sel_ctrl_b)
        readdata_nxt = {24'h000000, host_ext_mem_control_b_r};
      if (sel_addr)
        readdata_nxt = {16'h0000, addr_r};
      if (sel_wdata)
        readdata_nxt = {24'h000000, wdata_r};
      if (sel_status)
        readdata_nxt = status_word;
      if (sel_rdata)
        readdata_nxt = {24'h000000, rdata_r};
      if (sel_bank)
        readdata_nxt = {28'h0000000, bank_r};
    end
  end

  // first edge acks, second edge commits and re-arms
  assign waitrequest_nxt = ~(req & waitrequest_r & ~stall);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= BSD_ST_IDLE;
      cnt_r <= 4'h0;
      op_read_r <= 1'b0;
      region_r <= BSD_RGN_INTERNAL;
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h00000000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      op_read_r <= op_read_nxt;
      region_r <= region_nxt;
      waitrequest_r <= waitrequest_nxt;
      readdata_r <= readdata_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_r <= 8'h00;
      bank_r <= `BSD_BANK_RST;
      done_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      bank_r <= bank_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
    end
  end

  // software-owned registers change only on a committed write
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      host_ext_mem_control_a_r <= `BSD_CTRL_RST;
      host_ext_mem_control_b_r <= `BSD_CTRL_RST;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
    end
    else if (wr_commit)
    begin
      if (sel_ctrl_a)
        host_ext_mem_control_a_r <= avs_writedata_i[7:0];
      if (sel_ctrl_b)
        host_ext_mem_control_b_r <= avs_writedata_i[7:0];
      if (sel_addr & ~busy)
        addr_r <= avs_writedata_i[15:0];
      if (sel_wdata & ~busy)
        wdata_r <= avs_writedata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata_o = readdata_r;
  assign avs_waitrequest_o = waitrequest_r;
  assign host_port_low_addr_data_o = pins.ad;
  assign host_port_low_addr_data_oe_o = pins.ad_oe;
  assign host_port_high_addr_o = pins.a_hi;
  assign wr_b_o = pins.wr_b;
  assign rd_b_o = pins.rd_b;
  assign ale_o = pins.ale;

endmodule
`default_nettype wire

// >>> verif/bsd_host_monitor.sv
// assertions on the controller's avalon and memory bus pins
`timescale 1ns/1ps
`default_nettype none
module bsd_host_monitor
#(
  parameter int STROBE_CYC = 2
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [7:0] host_port_low_addr_data_o,
  input wire logic host_port_low_addr_data_oe_o,
  input wire logic [7:0] host_port_high_addr_o,
  input wire logic wr_b_o,
  input wire logic rd_b_o,
  input wire logic ale_o
);
  logic [7:0] low_cnt_r;
  logic [7:0] lo_addr_r;
  wire logic strb = !wr_b_o || !rd_b_o;
  wire logic bank_addr = (host_port_high_addr_o == 8'hff) &&
                         (lo_addr_r == 8'h01);
  // low address byte as the board latches it
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lo_addr_r <= 8'h00;
    else if (ale_o)
      lo_addr_r <= host_port_low_addr_data_o;
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      low_cnt_r <= 8'h00;
    else
      low_cnt_r <= strb ? low_cnt_r + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------------------------------
  // address phase, then data phase
  // ----------------------------------------------------------------
  sequence addr_out;
    ale_o && host_port_low_addr_data_oe_o;
  endsequence
  sequence addr_kept;
    !ale_o && host_port_low_addr_data_oe_o &&
      $stable(host_port_low_addr_data_o);
  endsequence
  chk_latch_order: assert property ($rose(ale_o) |-> addr_out ##1 addr_kept)
    else $error("address not held across latch fall");
  chk_addr_first: assert property ($fell(wr_b_o) || $fell(rd_b_o) |-> $past(ale_o, 2))
    else $error("strobe without address phase");
  chk_wr_drives: assert property (!wr_b_o |-> host_port_low_addr_data_oe_o)
    else $error("write strobe with bus released");
  chk_rd_floats: assert property (!rd_b_o |-> !host_port_low_addr_data_oe_o)
    else $error("read strobe while driving bus");
  chk_one_strobe: assert property (wr_b_o || rd_b_o)
    else $error("read and write strobes together");
  chk_strobe_width: assert property ($rose(wr_b_o) || $rose(rd_b_o) |-> low_cnt_r == STROBE_CYC)
    else $error("strobe width wrong");
  chk_hi_stable: assert property (strb |-> $stable(host_port_high_addr_o))
    else $error("upper address moved in strobe");
  chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low over one cycle");
  chk_wait_idle: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("answer without request");
  chk_bank_hi_zero: assert property (!wr_b_o && bank_addr |->
    host_port_low_addr_data_o[7:4] == 4'h0)
    else $error("bank write with upper bits set");
endmodule
bind bsd_host_ctrl bsd_host_monitor #(.STROBE_CYC(STROBE_CYC)) u_mon (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .host_port_low_addr_data_o(host_port_low_addr_data_o),
  .host_port_low_addr_data_oe_o(host_port_low_addr_data_oe_o),
  .host_port_high_addr_o(host_port_high_addr_o),
  .wr_b_o(wr_b_o), .rd_b_o(rd_b_o), .ale_o(ale_o));
`default_nettype wire

// >>> verif/bsd_board_model.sv
// behavioural board: bank register, banked sram, expansion port
`timescale 1ns/1ps
`default_nettype none
module bsd_board_model
(
  input wire logic rst_b_i,
  input wire logic [7:0] ad_i,
  input wire logic ad_oe_i,
  input wire logic [7:0] a_hi_i,
  input wire logic wr_b_i,
  input wire logic rd_b_i,
  input wire logic ale_i,
  output logic [7:0] ad_o
);
  bit [7:0] mem [0:524287];
  logic [7:0] lo_r = 8'h00;
  logic [3:0] bank_r = 4'h0;
  wire logic [15:0] a = {a_hi_i, lo_r};
  wire logic in_sram = a >= 16'h2200 && a <= 16'ha1ff;
  wire logic in_exp = a >= 16'ha200 && a <= 16'hfeff;
  wire logic exp_en_b = !(in_exp && !(rd_b_i && wr_b_i));
  wire logic [18:0] phys = {bank_r, 15'h0} + 19'(a - 16'h2200);
  wire logic [7:0] rd_byte = in_sram ? mem[phys] :
    !exp_en_b ? a[7:0] ^ a[15:8] :
    a == 16'hff01 ? {4'h0, bank_r} : 8'h00;
  // a released bus shows the inverse, never a stale value
  assign ad_o = ad_oe_i ? ad_i : !rd_b_i ? rd_byte : ~ad_i;
  always @(negedge ale_i)
    lo_r <= ad_i;
  always @(posedge wr_b_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      bank_r <= 4'h0;
    else if (a == 16'hff01)
      bank_r <= ad_i[3:0];
    else if (in_sram)
      mem[phys] <= ad_i;
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the banked board bus controller
`timescale 1ns/1ps
`default_nettype none
`include "bsd_map.svh"
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module tb;
  typedef struct {logic [31:0] e; logic [31:0] m;} bsd_note_t;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_o;
  logic [7:0] ad_in;
  logic [7:0] ad_out;
  logic ad_oe;
  logic [7:0] a_hi;
  logic wr_b;
  logic rd_b;
  logic ale;
  int errors = 0;
  int n_checks = 0;
  bsd_note_t notes[$];
  bsd_note_t nt;
  logic [31:0] q;
  logic [7:0] pat [0:31];
  logic [15:0] ea;
  bsd_host_ctrl #(.STROBE_CYC(2)) u_bsd_host_ctrl (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
    .host_port_low_addr_data_i(ad_in), .host_port_low_addr_data_o(ad_out),
    .host_port_low_addr_data_oe_o(ad_oe), .host_port_high_addr_o(a_hi),
    .wr_b_o(wr_b), .rd_b_o(rd_b), .ale_o(ale));
  bsd_board_model u_bsd_board_model (
    .rst_b_i(rst_b_i), .ad_i(ad_out), .ad_oe_i(ad_oe), .a_hi_i(a_hi),
    .wr_b_i(wr_b), .rd_b_i(rd_b), .ale_i(ale), .ad_o(ad_in));
  always #25 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // avalon master and checking
  // ----------------------------------------------------------------
  task automatic av(input logic [4:0] a, input logic w,
                    input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    // sampled at the rising edge: the answer and the data stand there
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wait_o !== 1'b0 && n < 200);
    if (n >= 200)
      errors++;
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdx(input logic [4:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    notes.push_back('{e, m});
    av(a, 1'b0, 32'h0);
  endtask
  // one bus cycle, then done and the decoded region
  task automatic bop(input logic [15:0] ba, input logic w,
                     input logic [7:0] d, input logic [1:0] rg);
    int n;
    n = 0;
    av(`BSD_OFS_ADDR, 1'b1, {16'h0, ba});
    av(`BSD_OFS_WDATA, 1'b1, {24'h0, d});
    av(`BSD_OFS_CMD, 1'b1, w ? 32'h1 : 32'h2);
    do
    begin
      rdx(`BSD_OFS_STATUS, 32'h0, 32'h0);
      n++;
    end
    while (q[1] !== 1'b1 && n < 50);
    if (n >= 50)
      errors++;
    rdx(`BSD_OFS_STATUS, {26'h0, rg, 4'h2}, 32'h37);
    av(`BSD_OFS_STATUS, 1'b1, 32'h6);
  endtask
  task automatic rdb(input logic [15:0] ba, input logic [7:0] e,
                     input logic [1:0] rg);
    bop(ba, 1'b0, 8'h00, rg);
    rdx(`BSD_OFS_RDATA, {24'h0, e}, 32'hff);
  endtask
  task automatic refuse(input logic [15:0] ba, input logic [31:0] c);
    av(`BSD_OFS_ADDR, 1'b1, {16'h0, ba});
    av(`BSD_OFS_CMD, 1'b1, c);
    rdx(`BSD_OFS_STATUS, 32'h4, 32'h7);
    av(`BSD_OFS_STATUS, 1'b1, 32'h6);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(negedge clk_i)
    if (rd && wait_o === 1'b0 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      if (nt.m !== 32'h0)
        `CHK(rdat & nt.m, nt.e & nt.m)
    end
  initial
  begin
    repeat (60000) @(posedge clk_i);
    errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    stop_test();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(18));
    for (int i = 0; i < 32; i++)
      pat[i] = 8'($urandom);
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rdx(`BSD_OFS_CTRL_A, 32'h0, 32'hff);
    rdx(`BSD_OFS_STATUS, 32'h0, 32'hf37);
    refuse(16'h2200, 32'h1);
    av(`BSD_OFS_CTRL_A, 1'b1, 32'h80);
    av(`BSD_OFS_CTRL_B, 1'b1, 32'h1);
    refuse(16'h2200, 32'h2);
    av(`BSD_OFS_CTRL_B, 1'b1, 32'h0);
    refuse(16'h21ff, 32'h2);
    refuse(16'h2200, 32'h3);
    $display("test refusal done");
    rdb(16'hff01, 8'h00, 2'h3);
    for (int b = 0; b < 16; b++)
    begin
      bop(16'hff01, 1'b1, {4'($urandom), 4'(b)}, 2'h3);
      rdb(16'hff01, {4'h0, 4'(b)}, 2'h3);
      rdx(`BSD_OFS_BANK, 32'(b), 32'hf);
      bop(16'h2200, 1'b1, pat[2*b], 2'h1);
      bop(16'ha1ff, 1'b1, pat[2*b+1], 2'h1);
    end
    for (int b = 0; b < 16; b++)
    begin
      bop(16'hff01, 1'b1, 8'(b), 2'h3);
      rdb(16'h2200, pat[2*b], 2'h1);
      rdb(16'ha1ff, pat[2*b+1], 2'h1);
    end
    $display("test banks done");
    for (int i = 0; i < 4; i++)
    begin
      ea = 16'ha200 + 16'($urandom_range(23807));
      ea = (i == 0) ? 16'ha200 : (i == 1) ? 16'hfeff : ea;
      rdb(ea, ea[7:0] ^ ea[15:8], 2'h2);
      bop(ea, 1'b1, pat[i], 2'h2);
    end
    bop(16'hff00, 1'b1, 8'h5a, 2'h3);
    rdb(16'hff00, 8'h00, 2'h3);
    rdb(16'ha1ff, pat[31], 2'h1);
    $display("test expansion done");
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    av(`BSD_OFS_CTRL_A, 1'b1, 32'h80);
    rdb(16'hff01, 8'h00, 2'h3);
    rdb(16'h2200, pat[0], 2'h1);
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
